// ===== rtl/obp_bus_port.sv
// Device end of an octal DDR pseudo-static RAM bus port.
// Assumes every pin is far slower than ref_clk; pins pass two flops first.
// The memory core feeds read bytes in through rd_*, takes writes on wr_*.
`timescale 1ns/1ns
module obp_bus_port import obp_pkg::*; #(
  parameter int LATENCY_CLOCKS = OBP_LATENCY_CLOCKS,
  parameter bit DIFF_CLOCK = 1'b0
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic bus_select_n,
  input wire logic bus_clk,
  input wire logic timing_ref_inv,
  input wire logic shifted_clock,
  input wire logic shifted_clock_inv,
  input wire logic [7:0] byte_lanes_i,
  output logic [7:0] byte_lanes_o,
  output logic byte_lanes_oe,
  input wire logic read_write_strobe_i,
  output logic read_write_strobe_o,
  output logic read_write_strobe_oe,
  output logic cmd_valid,
  output logic cmd_read,
  output logic [OBP_CA_BITS-1:0] cmd_address_phase,
  input wire logic rd_valid,
  output logic rd_ready,
  input wire logic [7:0] rd_data,
  output logic wr_valid,
  output logic [7:0] wr_data,
  output logic wr_mask
);
  // Wait counter is seven bits wide
  if (LATENCY_CLOCKS < 1 || LATENCY_CLOCKS > 16) begin
    $error("obp_bus_port: LATENCY_CLOCKS must be 1 to 16");
  end

  // Doubled latency only; counted in bus clock edges (two per clock)
  localparam int WAIT_EDGES = 2 * OBP_LATENCY_FACTOR * LATENCY_CLOCKS;
  localparam logic [6:0] WAIT_LAST = 7'(WAIT_EDGES - 1);
  localparam logic [2:0] CA_LAST = 3'(OBP_CA_BYTES - 1);

  // Two-flop synchronisers for every pin; stage one feeds stage two only
  logic [12:0] pin_m_q;
  logic [12:0] pin_s_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_m_q <= 13'h0001;
      pin_s_q <= 13'h0001;
    end else begin
      pin_m_q <= {read_write_strobe_i, byte_lanes_i, shifted_clock_inv,
                  shifted_clock, timing_ref_inv, bus_select_n};
      pin_s_q <= pin_m_q;
    end
  end

  logic bus_clk_m_q;
  logic bus_clk_s_q;
  logic sel_n_s;
  logic ck_s;
  logic psc_s;
  logic [7:0] lanes_s;
  logic strobe_s;
  assign sel_n_s = pin_s_q[0];
  assign lanes_s = pin_s_q[11:4];
  assign strobe_s = pin_s_q[12];
  // Differential mode uses the crossing of true and complement lines
  assign ck_s = DIFF_CLOCK ? (bus_clk_s_q & ~pin_s_q[1]) : bus_clk_s_q;
  assign psc_s = DIFF_CLOCK ? (pin_s_q[2] & ~pin_s_q[3]) : pin_s_q[2];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bus_clk_m_q <= 1'b0;
      bus_clk_s_q <= 1'b0;
    end else begin
      bus_clk_m_q <= bus_clk;
      bus_clk_s_q <= bus_clk_m_q;
    end
  end

  logic ck_prev_q;
  logic psc_prev_q;
  logic sel_prev_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ck_prev_q <= 1'b0;
      psc_prev_q <= 1'b0;
      sel_prev_q <= 1'b1;
    end else begin
      ck_prev_q <= ck_s;
      psc_prev_q <= psc_s;
      sel_prev_q <= sel_n_s;
    end
  end

  logic ck_edge;
  logic psc_edge;
  logic sel_fall;
  logic sel_rise;
  assign ck_edge = ck_s ^ ck_prev_q;
  assign psc_edge = psc_s ^ psc_prev_q;
  assign sel_fall = sel_prev_q && !sel_n_s;
  assign sel_rise = !sel_prev_q && sel_n_s;

  // Read data buffer between the core and the lanes
  logic fifo_valid;
  logic fifo_pop;
  logic [7:0] fifo_data;
  obp_fifo #(
    .WIDTH(8),
    .DEPTH(OBP_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .in_valid(rd_valid),
    .in_ready(rd_ready),
    .in_data(rd_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  obp_state_t state_q;
  logic [2:0] ca_cnt_q;
  logic [6:0] wait_cnt_q;
  logic [OBP_CA_BITS-1:0] ca_q;
  logic [OBP_CA_BITS-1:0] ca_d;
  assign ca_d = {ca_q[OBP_CA_BITS-9:0], lanes_s};

  // Byte leaves only on a shifted clock edge with data ready
  assign fifo_pop = (state_q == OBP_READ) && psc_edge && fifo_valid
                    && !sel_rise;

  // Sequencer; reset and select rising both abandon any transfer
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= OBP_IDLE;
      ca_cnt_q <= '0;
      wait_cnt_q <= '0;
      ca_q <= OBP_CA_RESET;
    end else if (sel_rise || sel_n_s) begin
      state_q <= OBP_IDLE;
      ca_cnt_q <= '0;
      wait_cnt_q <= '0;
    end else begin
      case (state_q)
        OBP_IDLE: begin
          if (sel_fall) begin
            state_q <= OBP_CMD;
          end
        end
        OBP_CMD: begin
          if (ck_edge) begin
            ca_q <= ca_d;
            ca_cnt_q <= ca_cnt_q + 3'h1;
            if (ca_cnt_q == CA_LAST) begin
              state_q <= OBP_WAIT;
            end
          end
        end
        OBP_WAIT: begin
          if (ck_edge) begin
            wait_cnt_q <= wait_cnt_q + 7'h01;
            // Always the long wait, never the single count
            if (wait_cnt_q == WAIT_LAST) begin
              state_q <= ca_q[OBP_RW_BIT] ? OBP_READ : OBP_WRITE;
            end
          end
        end
        OBP_READ: begin
          state_q <= OBP_READ;
        end
        OBP_WRITE: begin
          state_q <= OBP_WRITE;
        end
        default: begin
          state_q <= OBP_IDLE;
        end
      endcase
    end
  end

  // Command out to the core, one pulse when the last address byte lands
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cmd_valid <= 1'b0;
      cmd_read <= 1'b0;
      cmd_address_phase <= OBP_CA_RESET;
    end else begin
      cmd_valid <= 1'b0;
      if (state_q == OBP_CMD && ck_edge && ca_cnt_q == CA_LAST
          && !sel_n_s) begin
        cmd_valid <= 1'b1;
        cmd_read <= ca_d[OBP_RW_BIT];
        cmd_address_phase <= ca_d;
      end
    end
  end

  // Write bytes pass on with the strobe as their mask
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_valid <= 1'b0;
      wr_data <= OBP_LANES_RESET;
      wr_mask <= 1'b0;
    end else begin
      wr_valid <= 1'b0;
      if (state_q == OBP_WRITE && ck_edge && !sel_n_s) begin
        wr_valid <= 1'b1;
        wr_data <= lanes_s;
        wr_mask <= strobe_s;
      end
    end
  end

  // Pin drivers; all released under reset and outside transactions
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      byte_lanes_o <= OBP_LANES_RESET;
      byte_lanes_oe <= 1'b0;
      read_write_strobe_o <= 1'b0;
      read_write_strobe_oe <= 1'b0;
    end else if (sel_rise || sel_n_s) begin
      byte_lanes_oe <= 1'b0;
      read_write_strobe_oe <= 1'b0;
      read_write_strobe_o <= 1'b0;
    end else begin
      case (state_q)
        OBP_IDLE: begin
          // High flags extra latency, which this part always takes
          if (sel_fall) begin
            read_write_strobe_oe <= 1'b1;
            read_write_strobe_o <= 1'b1;
          end
        end
        OBP_WAIT: begin
          // Reads keep the strobe and park it low; writes hand it over
          read_write_strobe_oe <= ca_q[OBP_RW_BIT];
          read_write_strobe_o <= 1'b0;
        end
        OBP_READ: begin
          read_write_strobe_oe <= 1'b1;
          if (fifo_pop) begin
            byte_lanes_oe <= 1'b1;
            byte_lanes_o <= fifo_data;
            // One toggle per byte on either shifted clock edge
            read_write_strobe_o <= ~read_write_strobe_o;
          end
        end
        OBP_WRITE: begin
          read_write_strobe_oe <= 1'b0;
          byte_lanes_oe <= 1'b0;
        end
        default: begin
          read_write_strobe_oe <= read_write_strobe_oe;
        end
      endcase
    end
  end
endmodule

// ===== rtl/obp_fifo.sv
// Read-data FIFO with a registered output stage.
// Assumes one clock; both sides use valid and ready.
`timescale 1ns/1ns
module obp_fifo import obp_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int DEPTH = OBP_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // Pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin
    $error("obp_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic out_valid_q;
  logic [WIDTH-1:0] out_data_q;
  logic push;
  logic load;

  assign in_ready = (count_q != (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  // Output stage refills as soon as it empties or is taken
  assign load = (count_q != '0) && (!out_valid_q || out_ready);
  assign out_valid = out_valid_q;
  assign out_data = out_data_q;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (load) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end else if (load) begin
      out_valid_q <= 1'b1;
      out_data_q <= mem[rd_ptr_q];
    end else if (out_ready) begin
      out_valid_q <= 1'b0;
    end
  end
endmodule

// ===== rtl/obp_pkg.sv
// Constants shared by the octal DDR bus port and its read FIFO.
// Assumes all pins are sampled by ref_clk, far faster than the bus clock.
// What this block does
// - Command-address bytes come in on the eight byte lanes; data bytes travel on them both ways.
// - Reset low returns the port to idle and drops any transaction.
// - While reset is low, strobe and byte lanes are not driven.
// - The port drives the strobe during read data; the host does not.
// - Doubled initial latency is always used, whatever the strobe showed.
// - Read strobe edges are timed from the shifted clock, not bus clock.
// - Strobe flags extra latency at start; host masks write bytes with it.
// - Select falling opens a transaction; select rising ends it at once.
package obp_pkg;
  localparam int OBP_SYNC_STAGES = 2;
  localparam int OBP_CA_BYTES = 6;
  localparam int OBP_CA_BITS = 8 * OBP_CA_BYTES;
  localparam int OBP_RW_BIT = 47;
  localparam int OBP_LATENCY_CLOCKS = 4;
  localparam int OBP_LATENCY_FACTOR = 2;
  localparam int OBP_FIFO_DEPTH = 16;
  localparam logic [7:0] OBP_LANES_RESET = 8'h00;
  localparam logic [OBP_CA_BITS-1:0] OBP_CA_RESET = 48'h0;
  typedef enum logic [2:0] {
    OBP_IDLE, OBP_CMD, OBP_WAIT, OBP_READ, OBP_WRITE
  } obp_state_t;
endpackage

// ===== test/obp_bus_port_bench.sv
// Self-checking bench for the octal DDR bus port.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ns
module obp_bus_port_bench import obp_pkg::*;;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic rd_valid = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic [7:0] lanes_o, h_lanes;
  logic lanes_oe, ds_o, ds_oe, h_ds, sel_n, bclk, bclk_n, sclk, sclk_n;
  logic cmd_valid, cmd_read, rd_ready, wr_valid, wr_mask, ds_q, rd_seen;
  logic [7:0] wr_data;
  logic [47:0] cmd_ca, ca_seen;
  logic [7:0] got_rd[$], exp_rd[$];
  logic [8:0] got_wr[$], wq[$];
  int errors = 0;
  int compares = 0;
  int first_edge;
  int len;
  wire logic [7:0] lanes_w = lanes_oe ? lanes_o : h_lanes;
  wire logic ds_w = ds_oe ? ds_o : h_ds;
  always #50 ref_clk = ~ref_clk;
  obp_bus_port i_dut (.ref_clk, .nrst, .bus_select_n(sel_n), .bus_clk(bclk),
    .timing_ref_inv(bclk_n), .shifted_clock(sclk), .shifted_clock_inv(sclk_n),
    .byte_lanes_i(lanes_w), .byte_lanes_o(lanes_o), .byte_lanes_oe(lanes_oe),
    .read_write_strobe_i(ds_w), .read_write_strobe_o(ds_o),
    .read_write_strobe_oe(ds_oe), .cmd_valid, .cmd_read,
    .cmd_address_phase(cmd_ca), .rd_valid, .rd_ready, .rd_data, .wr_valid,
    .wr_data, .wr_mask);
  obp_host_model i_host (.ref_clk, .bus_select_n(sel_n), .bus_clk(bclk),
    .timing_ref_inv(bclk_n), .shifted_clock(sclk), .shifted_clock_inv(sclk_n),
    .lanes_out(h_lanes), .strobe_out(h_ds));
  always @(posedge ref_clk) begin
    // Host captures a byte on every strobe edge
    if (lanes_oe && ds_o !== ds_q) begin
      if (got_rd.size() == 0)
        first_edge = i_host.edge_no;
      got_rd.push_back(lanes_o);
    end
    ds_q <= ds_o;
    if (wr_valid)
      got_wr.push_back({wr_mask, wr_data});
    if (cmd_valid) begin
      ca_seen <= cmd_ca;
      rd_seen <= cmd_read;
    end
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    compares++;
    if (seen !== want) begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic close_out();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Core side offers up to n bytes, stopping early if the buffer refuses
  task automatic fill(input int n);
    rd_valid = 1'b1;
    for (int k = 0; k < n && rd_ready; k++) begin
      rd_data = 8'($urandom());
      exp_rd.push_back(rd_data);
      @(negedge ref_clk);
    end
    rd_valid = 1'b0;
  endtask
  // Read takes its bytes from exp_rd; n must be even
  task automatic txn(input logic rd, input int n);
    logic [47:0] ca;
    ca = {rd, 47'({$urandom(), $urandom()})};
    got_rd.delete();
    got_wr.delete();
    wq.delete();
    ca_seen = 'x;
    for (int i = 0; i < n && !rd; i++)
      wq.push_back(9'($urandom()));
    i_host.xfer(rd, ca, rd ? 20 + n : 16 + n, wq);
    check(ca_seen, ca);
    check(rd_seen, rd);
    if (rd) begin
      check(got_rd.size(), exp_rd.size());
      foreach (exp_rd[i]) check(got_rd[i], exp_rd[i]);
      check(first_edge >= 22, 1'h1);
    end else begin
      check(got_wr.size(), n);
      foreach (wq[i]) check(got_wr[i], wq[i]);
    end
    exp_rd.delete();
    $display("test done rd=%0d n=%0d", rd, n);
  endtask
  initial begin
    void'($urandom(44));
    repeat (16) @(negedge ref_clk);
    check(lanes_oe, 1'h0);
    check(ds_oe, 1'h0);
    nrst = 1'b1;
    repeat (4) @(negedge ref_clk);
    fill(24);
    check(exp_rd.size(), OBP_FIFO_DEPTH + 1);
    check(rd_ready, 1'h0);
    txn(1'b1, 18);
    check(rd_ready, 1'h1);
    txn(1'b0, 8);
    // Select rises in mid-wait; buffered bytes must survive
    fill(4);
    i_host.xfer(1'b1, 48'hFFFF_0000_1234, 10, wq);
    txn(1'b1, 4);
    // Reads buffer exactly the bytes that the host then collects
    for (int t = 0; t < 6; t++) begin
      len = 2 * (1 + $urandom() % 8);
      if (t % 2 == 0)
        fill(len);
      txn(t % 2 == 0, len);
    end
    fill(4);
    fork
      i_host.xfer(1'b1, 48'hFFFF_0000_0000, 30, wq);
      begin
        repeat (100) @(negedge ref_clk);
        nrst = 1'b0;
        @(negedge ref_clk);
        check(lanes_oe, 1'h0);
        check(ds_oe, 1'h0);
        check(rd_ready, 1'h1);
        nrst = 1'b1;
      end
    join
    $display("test done mid-transfer reset");
    exp_rd.delete();
    txn(1'b0, 6);
    close_out();
  end
  initial begin
    #5000000;
    errors++;
    close_out();
  end
endmodule

// ===== test/obp_bus_port_sva.sv
// Pin-level assertions for the octal DDR bus port.
// Assumes it sees only the ports of obp_bus_port, attached by bind.
`timescale 1ns/1ns
module obp_bus_port_sva import obp_pkg::*; (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic bus_select_n,
  input wire logic shifted_clock,
  input wire logic [7:0] byte_lanes_o,
  input wire logic byte_lanes_oe,
  input wire logic read_write_strobe_o,
  input wire logic read_write_strobe_oe,
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic [OBP_CA_BITS-1:0] cmd_address_phase,
  input wire logic wr_valid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  AST_RST_QUIET: assert property (
    $rose(nrst) |-> !byte_lanes_oe && !read_write_strobe_oe)
    else $error("pins driven after reset");
  AST_SEL_IDLE: assert property (
    bus_select_n [*5] |-> !byte_lanes_oe && !read_write_strobe_oe)
    else $error("pins driven while deselected");
  AST_CA_FLAG: assert property (
    $fell(bus_select_n) ##1 !bus_select_n [*5]
    |-> read_write_strobe_oe && read_write_strobe_o)
    else $error("strobe not flagging latency");
  AST_READ_STROBE: assert property (
    byte_lanes_oe |-> read_write_strobe_oe)
    else $error("read bytes without strobe");
  AST_WR_HOST: assert property (
    wr_valid |-> !byte_lanes_oe && !read_write_strobe_oe)
    else $error("port drives during write");
  AST_CMD_DIR: assert property (
    cmd_valid |-> cmd_read == cmd_address_phase[OBP_RW_BIT]
    && read_write_strobe_oe && read_write_strobe_o && !byte_lanes_oe)
    else $error("direction bit or latency flag wrong at command end");
  AST_LATENCY: assert property (
    cmd_valid |=> !byte_lanes_oe [*8])
    else $error("read data too early");
  AST_SHIFT_EDGE: assert property (
    $past(byte_lanes_oe) && byte_lanes_oe && $changed(read_write_strobe_o)
    |-> $past(shifted_clock, 3) != $past(shifted_clock, 6))
    else $error("strobe edge without shifted clock edge");
endmodule
bind obp_bus_port obp_bus_port_sva i_sva (.ref_clk, .nrst, .bus_select_n,
  .shifted_clock, .byte_lanes_o, .byte_lanes_oe, .read_write_strobe_o,
  .read_write_strobe_oe, .cmd_valid, .cmd_read, .cmd_address_phase,
  .wr_valid);

// ===== test/obp_host_model.sv
// Host controller model: select, bus clock, shifted clock, lanes, mask.
// Assumes the bench resolves lanes and strobe against the port's enables.
`timescale 1ns/1ns
module obp_host_model (
  input wire logic ref_clk,
  output logic bus_select_n = 1'b1,
  output logic bus_clk = 1'b0,
  output logic timing_ref_inv,
  output logic shifted_clock = 1'b0,
  output logic shifted_clock_inv,
  output logic [7:0] lanes_out = 8'h00,
  output logic strobe_out = 1'b0
);
  int edge_no = 0;
  assign timing_ref_inv = ~bus_clk;
  // Single-ended mode: held low rather than left floating
  assign shifted_clock_inv = 1'b0;
  task automatic xfer(input logic rd, input logic [47:0] ca, input int ne,
    input logic [8:0] wq[$]);
    edge_no = 0;
    @(negedge ref_clk);
    bus_select_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    for (int i = 0; i < 6 + ne; i++) begin
      if (i < 6)
        lanes_out = ca[47 - 8 * i -: 8];
      else if (!rd && i >= 22 && i - 22 < wq.size())
        {strobe_out, lanes_out} = wq[i - 22];
      else
        {strobe_out, lanes_out} = ~{strobe_out, lanes_out};
      repeat (2) @(negedge ref_clk);
      bus_clk = ~bus_clk;
      edge_no++;
      repeat (2) @(negedge ref_clk);
      // Quarter-period lag; still during writes
      if (rd)
        shifted_clock = bus_clk;
    end
    repeat (2) @(negedge ref_clk);
    bus_select_n = 1'b1;
    repeat (6) @(negedge ref_clk);
  endtask
endmodule
